// ==== hw/als_pkg.sv ====
// Purpose: Shared constants of the light sensor register bank
// Assumes: 250 MHz core clock, 8-bit registers
// Notes: Times are kept in their own units, cycles derived
package als_pkg;
  localparam int CLK_MHZ = 250;
  localparam logic [7:0] ADDR_STRAP_HI = 8'h96;
  localparam logic [7:0] ADDR_STRAP_LO = 8'h94;
  localparam logic [7:0] OFS_FLAG = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h01;
  localparam logic [7:0] OFS_SETUP = 8'h02;
  localparam logic [7:0] OFS_LUX_UP = 8'h03;
  localparam logic [7:0] OFS_LUX_LO = 8'h04;
  localparam logic [7:0] OFS_TOP = 8'h05;
  localparam logic [7:0] OFS_BOTTOM = 8'h06;
  localparam logic [7:0] OFS_PERSIST = 8'h07;
  localparam logic [7:0] RST_FLAG = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_SETUP = 8'h03;
  localparam logic [7:0] RST_LUX = 8'h00;
  localparam logic [7:0] RST_TOP = 8'hff;
  localparam logic [7:0] RST_BOTTOM = 8'h00;
  localparam logic [7:0] RST_PERSIST = 8'hff;
  localparam int BIT_ALWAYS = 7;
  localparam int BIT_MANUAL = 6;
  localparam int BIT_DIVIDE = 3;
  localparam logic [2:0] CODE_100MS = 3'h3;
  localparam logic [2:0] CODE_LONGEST = 3'h0;
  localparam logic [3:0] EXP_OVER = 4'hf;
  localparam int MEAS_PERIOD_MS = 800;
  localparam int MIN_INTEG_NS = 6250000;
  localparam int PERSIST_TICK_MS = 100;
  localparam int MEAS_PERIOD_CYC = MEAS_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int MIN_INTEG_CYC = MIN_INTEG_NS / 1000 * CLK_MHZ;
  localparam int PERSIST_TICK_CYC = PERSIST_TICK_MS * 1000 * CLK_MHZ;
  typedef enum logic [2:0] {
    ALS_IDLE = 3'b000,
    ALS_ADDR = 3'b001,
    ALS_ACK = 3'b010,
    ALS_WR = 3'b011,
    ALS_RD = 3'b100,
    ALS_RACK = 3'b101
  } als_bus_st_t;
endpackage : als_pkg

// ==== hw/als_regs_irq.sv ====
// Purpose: Serial-bus register bank, measurement pacing and event logic
// Assumes: Bus pins and strap are asynchronous; conv_code_in is local
// Notes: Conversion result arrives on conv_code_in at integration end
`timescale 1ns/1ns
module als_regs_irq #(
  parameter int MEAS_PERIOD_CYC = als_pkg::MEAS_PERIOD_CYC,
  parameter int MIN_INTEG_CYC = als_pkg::MIN_INTEG_CYC,
  parameter int PERSIST_TICK_CYC = als_pkg::PERSIST_TICK_CYC
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic addr_strap_pin_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic int_pin_out,
  output logic int_pin_oe_out,
  input wire logic [11:0] conv_code_in,
  output logic integ_active_out,
  output logic [2:0] integ_code_out,
  output logic photo_current_divide_out
);
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d, strap_s1, strap_s2;
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      {scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d} <= 6'h3f;
      {strap_s1, strap_s2} <= 2'h0;
    end
    else
    begin
      {scl_s1, scl_s2, scl_d} <= {scl_in, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {sda_in, sda_s1, sda_s2};
      {strap_s1, strap_s2} <= {addr_strap_pin_in, strap_s1};
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [6:0] my_addr;
  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;
  assign my_addr = strap_s2 ? als_pkg::ADDR_STRAP_HI[7:1]
                            : als_pkg::ADDR_STRAP_LO[7:1];

  als_pkg::als_bus_st_t st, next_st;
  logic [3:0] bitc, next_bitc;
  logic [7:0] sh, next_sh, idx, next_idx;
  logic rw, next_rw, have_idx, next_have_idx, nack, next_nack;
  logic sda_drv, next_sda_drv, freeze, next_freeze;
  logic flag, next_flag, enable, next_enable;
  logic [7:0] setup, next_setup, top, next_top, bottom, next_bottom;
  logic [7:0] ptimer, next_ptimer;
  logic wr_en, rd_clr, en_clr, addr_hit, ev_set;
  logic [7:0] lux_up;
  logic [3:0] lux_lo;
  logic [2:0] auto_code, eff_code;
  logic auto_cdr, eff_cdr;

  assign eff_code = setup[als_pkg::BIT_MANUAL] ? setup[2:0] : auto_code;
  assign eff_cdr = setup[als_pkg::BIT_MANUAL] ?
                   setup[als_pkg::BIT_DIVIDE] : auto_cdr;

  // Unimplemented indices and bits read as zero
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    case (a)
      als_pkg::OFS_FLAG: rd_mux = {7'h0, flag};
      als_pkg::OFS_ENABLE: rd_mux = {7'h0, enable};
      als_pkg::OFS_SETUP: rd_mux = {setup[7:6], 2'h0, eff_cdr, eff_code};
      als_pkg::OFS_LUX_UP: rd_mux = lux_up;
      als_pkg::OFS_LUX_LO: rd_mux = {4'h0, lux_lo};
      als_pkg::OFS_TOP: rd_mux = top;
      als_pkg::OFS_BOTTOM: rd_mux = bottom;
      als_pkg::OFS_PERSIST: rd_mux = ptimer;
      default: rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  always_comb
  begin
    next_st = st;
    next_bitc = bitc;
    next_sh = sh;
    next_idx = idx;
    next_rw = rw;
    next_have_idx = have_idx;
    next_nack = nack;
    next_sda_drv = sda_drv;
    next_freeze = freeze;
    wr_en = 1'b0;
    rd_clr = 1'b0;
    addr_hit = 1'b0;
    if (bus_stop)
    begin
      next_st = als_pkg::ALS_IDLE;
      next_freeze = 1'b0;
      next_sda_drv = 1'b0;
    end
    else if (bus_start)
    begin
      next_st = als_pkg::ALS_ADDR;
      next_bitc = 4'h0;
      next_sda_drv = 1'b0;
    end
    else if (scl_rise)
    begin
      if (st == als_pkg::ALS_ADDR || st == als_pkg::ALS_WR)
      begin
        next_sh = {sh[6:0], sda_s2};
        next_bitc = bitc + 4'h1;
      end
      else if (st == als_pkg::ALS_RACK)
        next_nack = sda_s2;
    end
    else if (scl_fall)
    begin
      case (st)
        als_pkg::ALS_ADDR:
          if (bitc == 4'h8)
          begin
            if (sh[7:1] == my_addr)
            begin
              addr_hit = 1'b1;
              next_sda_drv = 1'b1;
              next_rw = sh[0];
              next_freeze = 1'b1;
              next_have_idx = sh[0] & have_idx;
              next_st = als_pkg::ALS_ACK;
            end
            else
              next_st = als_pkg::ALS_IDLE;
          end
        als_pkg::ALS_WR:
          if (bitc == 4'h8)
          begin
            next_sda_drv = 1'b1;
            next_st = als_pkg::ALS_ACK;
            next_have_idx = 1'b1;
            if (!have_idx)
              next_idx = sh;
            else
              wr_en = 1'b1;
          end
        als_pkg::ALS_ACK, als_pkg::ALS_RACK:
          if (st == als_pkg::ALS_RACK && nack)
          begin
            next_sda_drv = 1'b0;
            next_st = als_pkg::ALS_IDLE;
          end
          else if (rw)
          begin
            next_sh = rd_mux(idx);
            next_sda_drv = ~next_sh[7];
            next_bitc = 4'h0;
            next_st = als_pkg::ALS_RD;
            rd_clr = (idx == als_pkg::OFS_FLAG);
          end
          else
          begin
            next_sda_drv = 1'b0;
            next_bitc = 4'h0;
            next_st = als_pkg::ALS_WR;
          end
        als_pkg::ALS_RD:
          if (bitc == 4'h7)
          begin
            next_sda_drv = 1'b0;
            next_st = als_pkg::ALS_RACK;
          end
          else
          begin
            next_sh = {sh[6:0], 1'b0};
            next_sda_drv = ~sh[6];
            next_bitc = bitc + 4'h1;
          end
        default: next_st = als_pkg::ALS_IDLE;
      endcase
    end
  end

  always_comb
  begin
    next_enable = enable;
    next_setup = setup;
    next_top = top;
    next_bottom = bottom;
    next_ptimer = ptimer;
    if (wr_en)
    begin
      case (idx)
        als_pkg::OFS_ENABLE: next_enable = sh[0];
        als_pkg::OFS_SETUP:
          // Code and divide only stick when written in manual mode
          next_setup = sh[als_pkg::BIT_MANUAL] ?
                       {sh[7:6], 2'h0, sh[3:0]} :
                       {sh[7:6], 2'h0, setup[3:0]};
        als_pkg::OFS_TOP: next_top = sh;
        als_pkg::OFS_BOTTOM: next_bottom = sh;
        als_pkg::OFS_PERSIST: next_ptimer = sh;
        default: next_enable = enable;
      endcase
    end
    // A new event wins over a status-read clear in the same cycle
    next_flag = (flag & ~rd_clr & ~en_clr) | ev_set;
  end

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      st <= als_pkg::ALS_IDLE;
      bitc <= 4'h0;
      sh <= 8'h00;
      idx <= 8'h00;
      {rw, have_idx, nack, sda_drv, freeze} <= 5'h0;
      flag <= als_pkg::RST_FLAG[0];
      enable <= als_pkg::RST_ENABLE[0];
      setup <= als_pkg::RST_SETUP;
      top <= als_pkg::RST_TOP;
      bottom <= als_pkg::RST_BOTTOM;
      ptimer <= als_pkg::RST_PERSIST;
    end
    else
    begin
      st <= next_st;
      bitc <= next_bitc;
      sh <= next_sh;
      idx <= next_idx;
      {rw, have_idx, nack, sda_drv, freeze} <=
        {next_rw, next_have_idx, next_nack, next_sda_drv, next_freeze};
      flag <= next_flag;
      enable <= next_enable;
      setup <= next_setup;
      top <= next_top;
      bottom <= next_bottom;
      ptimer <= next_ptimer;
    end
  end

  // Measurement pacing, autoranging, result capture and persistence
  logic [31:0] integ_cnt, next_integ_cnt, gap_cnt, next_gap_cnt;
  logic [31:0] tick_cnt, next_tick_cnt, integ_len;
  logic integ_on, next_integ_on, pend, next_pend;
  logic [11:0] pend_code, next_pend_code, new_code;
  logic [7:0] next_lux_up;
  logic [3:0] next_lux_lo;
  logic [2:0] next_auto_code;
  logic next_auto_cdr;
  logic [8:0] pcount, next_pcount;
  logic conv_done, gap_hit, tick, meas_start, out_win, have;

  assign integ_len = 32'(MIN_INTEG_CYC) << (3'h7 - eff_code);
  // Ends at once if a shorter code cuts a running integration, no hang
  assign conv_done = integ_on && (integ_cnt >= integ_len - 32'h1);
  assign gap_hit = (gap_cnt == 32'(MEAS_PERIOD_CYC) - 32'h1);
  assign tick = (tick_cnt == 32'(PERSIST_TICK_CYC) - 32'h1);
  assign meas_start = (!integ_on || conv_done) &&
                      (setup[als_pkg::BIT_ALWAYS] || gap_hit);
  assign out_win = (lux_up > top) || (lux_up < bottom);
  assign en_clr = wr_en && idx == als_pkg::OFS_ENABLE && !sh[0];
  // Disable write blocks a same-cycle event: no flag with enable off
  assign ev_set = enable && !en_clr && out_win &&
                  (pcount > {1'b0, ptimer});

  always_comb
  begin
    next_gap_cnt = gap_hit ? 32'h0 : gap_cnt + 32'h1;
    next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
    next_integ_on = meas_start ? 1'b1 : (conv_done ? 1'b0 : integ_on);
    next_integ_cnt = meas_start ? 32'h0 : integ_cnt + 32'h1;
    next_auto_code = auto_code;
    next_auto_cdr = auto_cdr;
    if (conv_done)
    begin
      // Step toward shorter time or divided current on overrange
      if (conv_code_in[11:8] == als_pkg::EXP_OVER)
      begin
        if (auto_code != als_pkg::CODE_100MS)
          next_auto_code = auto_code + 3'h1;
        else
          next_auto_cdr = 1'b1;
      end
      else if (conv_code_in[11:4] == 8'h00)
      begin
        if (auto_cdr)
          next_auto_cdr = 1'b0;
        else if (auto_code != als_pkg::CODE_LONGEST)
          next_auto_code = auto_code - 3'h1;
      end
    end
    // A result held off by a bus access is posted after stop
    have = conv_done | pend;
    new_code = conv_done ? conv_code_in : pend_code;
    next_lux_up = lux_up;
    next_lux_lo = lux_lo;
    next_pend = have;
    next_pend_code = new_code;
    if (have && !freeze)
    begin
      next_lux_up = new_code[11:4];
      next_lux_lo = new_code[3:0];
      next_pend = 1'b0;
    end
    if (!out_win)
      next_pcount = 9'h000;
    else if (tick && pcount != 9'h1ff)
      next_pcount = pcount + 9'h001;
    else
      next_pcount = pcount;
  end

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      gap_cnt <= 32'h0;
      tick_cnt <= 32'h0;
      integ_cnt <= 32'h0;
      integ_on <= 1'b0;
      auto_code <= als_pkg::CODE_100MS;
      auto_cdr <= 1'b0;
      pend <= 1'b0;
      pend_code <= 12'h000;
      lux_up <= als_pkg::RST_LUX;
      lux_lo <= als_pkg::RST_LUX[3:0];
      pcount <= 9'h000;
    end
    else
    begin
      gap_cnt <= next_gap_cnt;
      tick_cnt <= next_tick_cnt;
      integ_cnt <= next_integ_cnt;
      integ_on <= next_integ_on;
      auto_code <= next_auto_code;
      auto_cdr <= next_auto_cdr;
      pend <= next_pend;
      pend_code <= next_pend_code;
      lux_up <= next_lux_up;
      lux_lo <= next_lux_lo;
      pcount <= next_pcount;
    end
  end

  // Both pins are open drain: the low level is fixed, the enable acts
  assign sda_out = 1'b0;
  assign sda_oe_out = sda_drv;
  assign int_pin_out = 1'b0;
  assign int_pin_oe_out = flag;
  assign integ_active_out = integ_on;
  assign integ_code_out = eff_code;
  assign photo_current_divide_out = eff_cdr;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  property p_pin_flag;
    int_pin_oe_out == flag && !int_pin_out;
  endproperty
  a_pin_flag: assert property (p_pin_flag)
    else $error("interrupt pin does not follow the flag");
  property p_off_quiet;
    !enable |-> !flag && !int_pin_oe_out;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("flag or pin set while disabled");
  property p_set;
    ev_set |=> flag && int_pin_oe_out;
  endproperty
  a_set: assert property (p_set)
    else $error("event did not set the flag");
  property p_read_clear;
    rd_clr && !ev_set |=> !flag;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("flag survived a status read");
  property p_en_clear;
    wr_en && idx == als_pkg::OFS_ENABLE && !sh[0] |=> !flag ##1 !flag;
  endproperty
  a_en_clear: assert property (p_en_clear)
    else $error("flag survived enable write of zero");
  property p_addr_ack;
    addr_hit |=> sda_oe_out && freeze && st == als_pkg::ALS_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("matched address not acknowledged");
  property p_freeze;
    freeze |=> $stable(lux_up) && $stable(lux_lo);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("result changed while frozen");
  property p_restart;
    conv_done && setup[als_pkg::BIT_ALWAYS] |=> integ_on && integ_cnt == 0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("always-measure did not restart");
  property p_window;
    !out_win |=> pcount == 9'h000 || out_win;
  endproperty
  a_window: assert property (p_window)
    else $error("persistence count not restarted");
endmodule : als_regs_irq

// ==== testbench/als_host_model.sv ====
// Purpose: Bus master model for the sensor's serial register port
// Assumes: Open-drain bus resolved in the bench with a pull-up
// Notes: Bit cell of 31 core clocks (124 ns); low_extra slows the master
`timescale 1ns/1ns
module als_host_model (
  input wire logic clock_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  int low_extra = 0;
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask : wait_cyc
  // Data moves only mid-low, so no false START or STOP while SCL is high
  task automatic bit_io(input logic b, output logic s);
    wait_cyc(7 + low_extra);
    sda_low_out <= ~b;
    wait_cyc(8);
    scl_out <= 1'b1;
    wait_cyc(8);
    s = sda_in;
    wait_cyc(8);
    scl_out <= 1'b0;
  endtask : bit_io
  task automatic frame_edge(input logic is_start);
    wait_cyc(7);
    sda_low_out <= ~is_start;
    wait_cyc(8);
    scl_out <= 1'b1;
    wait_cyc(8);
    sda_low_out <= is_start;
    wait_cyc(8);
    scl_out <= ~is_start;
  endtask : frame_edge
  task automatic byte_io(input logic [7:0] d, input logic ack_in,
                         output logic [7:0] r, output logic ack_out);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(ack_in, ack_out);
  endtask : byte_io
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] idx,
                           input logic [7:0] d, output logic [2:0] nak);
    logic [7:0] r;
    frame_edge(1'b1);
    byte_io(addr & 8'hfe, 1'b1, r, nak[2]);
    byte_io(idx, 1'b1, r, nak[1]);
    byte_io(d, 1'b1, r, nak[0]);
    frame_edge(1'b0);
  endtask : write_reg
  // Index only, then repeated START so the result bytes stay frozen
  task automatic read_reg(input logic [7:0] addr, input logic [7:0] idx,
                          output logic [7:0] d, output logic nak);
    logic [7:0] r;
    logic n;
    frame_edge(1'b1);
    byte_io(addr & 8'hfe, 1'b1, r, nak);
    byte_io(idx, 1'b1, r, n);
    frame_edge(1'b1);
    byte_io(addr | 8'h01, 1'b1, r, n);
    byte_io(8'hff, 1'b1, d, n);
    frame_edge(1'b0);
  endtask : read_reg
endmodule : als_host_model

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the sensor register bank and event pin
// Assumes: Shortened pacing parameters; bus from als_host_model
// Notes: Light level is set directly on the converter result input
`timescale 1ns/1ns
module testbench;
  typedef struct {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] want;
  } als_row_t;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic addr_strap_pin_in = 1'b1;
  logic [11:0] conv_code_in = 12'h345;
  logic scl, host_low, sda_oe, int_oe;
  logic [2:0] icode;
  logic photo_current_divide, iact, sda_lvl, int_lvl;
  logic [7:0] dev_addr = 8'h96;
  logic [7:0] rv;
  logic [2:0] nak;
  wire sda_wire = ~(host_low | sda_oe);
  wire int_n = ~int_oe;
  int miscompares = 0;
  int n_compared = 0;
  als_row_t rows [8] = '{'{8'h05, 8'h40, 8'h40}, '{8'h06, 8'h10, 8'h10},
    '{8'h07, 8'h02, 8'h02}, '{8'h00, 8'hff, 8'h00}, '{8'h03, 8'h00, 8'h34},
    '{8'h04, 8'hff, 8'h05}, '{8'h01, 8'h01, 8'h01}, '{8'h02, 8'hc5, 8'hc5}};
  logic [7:0] rst_vals [8] = '{als_pkg::RST_FLAG, als_pkg::RST_ENABLE,
    als_pkg::RST_SETUP, als_pkg::RST_LUX, als_pkg::RST_LUX,
    als_pkg::RST_TOP, als_pkg::RST_BOTTOM, als_pkg::RST_PERSIST};
  always #2 clock_in = ~clock_in;
  als_regs_irq #(
    .MEAS_PERIOD_CYC(400),
    .MIN_INTEG_CYC(2),
    .PERSIST_TICK_CYC(10)
  ) als_regs_irq_i (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .addr_strap_pin_in(addr_strap_pin_in),
    .scl_in(scl),
    .sda_in(sda_wire),
    .sda_out(sda_lvl),
    .sda_oe_out(sda_oe),
    .int_pin_out(int_lvl),
    .int_pin_oe_out(int_oe),
    .conv_code_in(conv_code_in),
    .integ_active_out(iact),
    .integ_code_out(icode),
    .photo_current_divide_out(photo_current_divide)
  );
  als_host_model als_host_model_i (
    .clock_in(clock_in),
    .sda_in(sda_wire),
    .scl_out(scl),
    .sda_low_out(host_low)
  );
  task automatic chk8(input logic [7:0] got, input logic [7:0] want);
    n_compared++;
    if (got !== want)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h want=%h", $time, got, want);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic want);
    n_compared++;
    if (got !== want)
    begin
      miscompares++;
      $display("[ERR] t=%0t pin got=%h want=%h", $time, got, want);
    end
  endtask : chk1
  task automatic done(input string name);
    $display("Test %s finished", name);
  endtask : done
  task automatic end_sim;
    $display("Compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    als_host_model_i.write_reg(dev_addr, idx, d, nak);
    chk1(|nak, 1'b0);
  endtask : wr
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] want);
    als_host_model_i.read_reg(dev_addr, idx, rv, nak[0]);
    chk1(nak[0], 1'b0);
    chk8(rv, want);
  endtask : rd_chk
  // Bounded wait; a stuck pin shows up as a mismatch
  task automatic wait_int(input logic want);
    for (int k = 0; k < 2000 && int_oe !== want; k++)
      @(posedge clock_in);
    chk1(int_n, ~want);
  endtask : wait_int
  initial
  begin
    #380000;
    miscompares++;
    end_sim;
  end
  initial
  begin
    repeat (3) @(posedge clock_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    foreach (rows[i])
    begin
      wr(rows[i].idx, rows[i].wd);
      rd_chk(rows[i].idx, rows[i].want);
    end
    chk8({5'h00, icode}, 8'h05);
    wr(8'h02, 8'h80);
    chk1(iact, 1'b1);
    rd_chk(8'h02, 8'h83);
    done("register table");
    conv_code_in <= 12'h505;
    wait_int(1'b1);
    conv_code_in <= 12'h345;
    repeat (200) @(posedge clock_in);
    rd_chk(8'h00, 8'h01);
    rd_chk(8'h00, 8'h00);
    chk1(int_n, 1'b1);
    conv_code_in <= 12'h050;
    wait_int(1'b1);
    conv_code_in <= 12'h345;
    repeat (200) @(posedge clock_in);
    wr(8'h01, 8'h00);
    chk1(int_n, 1'b1);
    rd_chk(8'h00, 8'h00);
    conv_code_in <= 12'h505;
    repeat (1000) @(posedge clock_in);
    chk1(int_n, 1'b1);
    rd_chk(8'h00, 8'h00);
    done("event flag");
    conv_code_in <= 12'h345;
    wr(8'h07, 8'h14);
    wr(8'h01, 8'h01);
    for (int k = 0; k < 3; k++)
    begin
      conv_code_in <= 12'h505;
      repeat (120) @(posedge clock_in);
      conv_code_in <= 12'h345;
      repeat (120) @(posedge clock_in);
    end
    chk1(int_n, 1'b1);
    conv_code_in <= 12'h505;
    wait_int(1'b1);
    done("persistence restart");
    conv_code_in <= 12'hf00;
    repeat (100) @(posedge clock_in);
    chk1(photo_current_divide, 1'b1);
    rd_chk(8'h02, 8'h8b);
    conv_code_in <= 12'h000;
    repeat (600) @(posedge clock_in);
    chk1(photo_current_divide, 1'b0);
    chk8({5'h00, icode}, 8'h00);
    rd_chk(8'h02, 8'h80);
    conv_code_in <= 12'h345;
    done("autorange");
    rst_b_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    chk1(int_n, 1'b1);
    chk8({5'h00, icode}, 8'h03);
    chk1(iact, 1'b0);
    chk8({6'h00, sda_lvl, int_lvl}, 8'h00);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    for (int k = 0; k < 8; k++)
      if (k != 3 && k != 4)
        rd_chk(8'(k), rst_vals[k]);
    done("reset values");
    addr_strap_pin_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    als_host_model_i.write_reg(8'h96, 8'h05, 8'h5a, nak);
    chk1(&nak, 1'b1);
    dev_addr = 8'h94;
    als_host_model_i.low_extra = 40;
    rd_chk(8'h05, 8'hff);
    done("strap select");
    end_sim;
  end
endmodule : testbench
